// file: logic/mresr_top.sv
// Top-cell configuration and measurement result registers on APB
// Function
// - A four-bit highest-used-channel field sits in the low bits of its register and resets to twelve.
// - Balance-switch diagnostic alerts of channels above the highest used channel are masked.
// - A highest-used-channel value of zero masks alerts like the default of twelve, but the register reads back zero.
// - Twelve consecutive cell result registers hold each 14-bit result in bits 15 to 2.
// - Cell result registers read zero in bits 1 to 0 and are read-only.
// - The block-voltage result register holds its 14-bit result in bits 15 to 2.
// - The block-voltage result register reads zero in bits 1 to 0 and is read-only.
// - The first auxiliary result register holds its 12-bit result in bits 15 to 4.
// - The first auxiliary result register reads zero in bits 3 to 0 and is read-only.
`timescale 1ns/10ps
module mresr_top import mresr_pkg::*; #(
	parameter int NUM_CELLS = MRESR_NUM_CELLS
) (
	input  wire logic                 pclk,
	input  wire logic                 presetn,
	input  wire logic                 psel,
	input  wire logic                 penable,
	input  wire logic                 pwrite,
	input  wire logic [11:0]          paddr,
	input  wire logic [31:0]          pwdata,
	input  wire logic [3:0]           pstrb,
	output      logic [31:0]          prdata,
	output      logic                 pready,
	output      logic                 pslverr,
	input  wire logic                 conv_valid,
	input  wire logic [3:0]           conv_slot,
	input  wire logic [13:0]          conv_data,
	input  wire logic [NUM_CELLS-1:0] balance_switch_diag_alert_raw,
	output      logic [NUM_CELLS-1:0] balance_switch_diag_alert,
	output      logic [3:0]           highest_used_channel,
	output      logic                 irq
);

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	if (NUM_CELLS != MRESR_NUM_CELLS) begin : g_chk
		$error("mresr_top: register map is fixed at twelve cells");
	end

	// ------------------------------------------------------------
	// Decode
	// ------------------------------------------------------------
	function automatic logic is_result_idx(input logic [9:0] idx);
		is_result_idx = (idx >= MRESR_IDX_CELL_FIRST) && (idx <= MRESR_IDX_AUX_ONE);
	endfunction : is_result_idx

	logic [9:0]  idx;
	logic        addr_ok_align;
	logic        sel_top;
	logic        sel_result;
	logic        sel_status;
	logic        sel_enable;
	logic        sel_clear;
	logic        mapped;
	logic        setup;
	logic        access;
	logic        wr_access;
	logic [3:0]  rd_slot;
	logic [15:0] rd_result;

	assign idx           = paddr[11:2];
	assign addr_ok_align = (paddr[1:0] == 2'h0);
	assign sel_top       = addr_ok_align && (idx == MRESR_IDX_TOP_CELL);
	assign sel_result    = addr_ok_align && is_result_idx(idx);
	assign sel_status    = addr_ok_align && (idx == MRESR_IDX_IRQ_STATUS);
	assign sel_enable    = addr_ok_align && (idx == MRESR_IDX_IRQ_ENABLE);
	assign sel_clear     = addr_ok_align && (idx == MRESR_IDX_IRQ_CLEAR);
	assign mapped        = sel_top || sel_result || sel_status || sel_enable || sel_clear;
	assign setup         = psel && !penable;
	assign access        = psel && penable;
	assign wr_access     = access && pwrite && pstrb[0];
	assign rd_slot       = sel_result ? 4'(idx - MRESR_IDX_CELL_FIRST) : 4'h0;

	// Zero wait states; read data captured in the setup cycle
	assign pready = 1'b1;

	// ------------------------------------------------------------
	// Conversion path into the result store
	// ------------------------------------------------------------
	mresr_conv_if conv_bus ();

	assign conv_bus.valid = conv_valid;
	assign conv_bus.slot  = conv_slot;
	assign conv_bus.data  = conv_data;

	mresr_result_store #(
		.NUM_SLOTS (MRESR_NUM_RESULTS)
	) u_store (
		.pclk     (pclk),
		.presetn  (presetn),
		.conv     (conv_bus.dst),
		.rd_slot  (rd_slot),
		.rd_value (rd_result)
	);

	// ------------------------------------------------------------
	// Top-cell configuration
	// ------------------------------------------------------------
	logic [3:0] top_cell_q;
	logic [3:0] top_eff;
	logic [NUM_CELLS-1:0] masked_alert;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			top_cell_q <= MRESR_TOP_CELL_RST;
		end else if (wr_access && sel_top) begin
			top_cell_q <= pwdata[MRESR_TOP_BITS-1:0];
		end
	end

	mresr_alert_mask #(
		.NUM_CELLS (NUM_CELLS)
	) u_mask (
		.top_cfg      (top_cell_q),
		.raw_alert    (balance_switch_diag_alert_raw),
		.top_eff      (top_eff),
		.masked_alert (masked_alert)
	);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			balance_switch_diag_alert <= '0;
			highest_used_channel      <= MRESR_TOP_CELL_RST;
		end else begin
			balance_switch_diag_alert <= masked_alert;
			highest_used_channel      <= top_eff;
		end
	end

	// ------------------------------------------------------------
	// Interrupts
	// ------------------------------------------------------------
	logic [MRESR_NUM_EV-1:0] ev_set;
	logic [MRESR_NUM_EV-1:0] ev_clr;
	logic [MRESR_NUM_EV-1:0] irq_status_q;
	logic [MRESR_NUM_EV-1:0] irq_enable_q;
	logic                    alert_any_q;
	logic                    alert_any;

	assign alert_any = |masked_alert;
	assign ev_set[MRESR_EV_CELL]  = conv_valid && (conv_slot < MRESR_SLOT_BLOCK);
	assign ev_set[MRESR_EV_BLOCK] = conv_valid && (conv_slot == MRESR_SLOT_BLOCK);
	assign ev_set[MRESR_EV_AUX]   = conv_valid && (conv_slot == MRESR_SLOT_AUX_ONE);
	assign ev_set[MRESR_EV_ALERT] = alert_any && !alert_any_q;
	assign ev_clr = (wr_access && sel_clear) ? pwdata[MRESR_NUM_EV-1:0] : '0;

	// A set in the clearing cycle is kept
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_status_q <= '0;
			irq_enable_q <= MRESR_IRQ_EN_RST;
			alert_any_q  <= 1'b0;
			irq          <= 1'b0;
		end else begin
			irq_status_q <= (irq_status_q & ~ev_clr) | ev_set;
			alert_any_q  <= alert_any;
			irq          <= |(((irq_status_q & ~ev_clr) | ev_set) & irq_enable_q);
			if (wr_access && sel_enable) begin
				irq_enable_q <= pwdata[MRESR_NUM_EV-1:0];
			end
		end
	end

	// ------------------------------------------------------------
	// Read data
	// ------------------------------------------------------------
	logic [31:0] rd_mux;

	assign rd_mux = sel_top    ? {28'h0, top_cell_q} :
	                sel_result ? {16'h0, rd_result} :
	                sel_status ? {28'h0, irq_status_q} :
	                sel_enable ? {28'h0, irq_enable_q} :
	                32'h0;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata  <= 32'h0;
			pslverr <= 1'b0;
		end else if (setup) begin
			prdata  <= pwrite ? 32'h0 : rd_mux;
			pslverr <= !mapped;
		end
	end

endmodule : mresr_top

// file: logic/mresr_pkg.sv
// Shared constants for the measurement result register bank
package mresr_pkg;

	// ------------------------------------------------------------
	// Register indices (byte address is four times the index)
	// ------------------------------------------------------------
	localparam logic [9:0] MRESR_IDX_TOP_CELL   = 10'h01e;
	localparam logic [9:0] MRESR_IDX_CELL_FIRST = 10'h020;
	localparam logic [9:0] MRESR_IDX_CELL_LAST  = 10'h02b;
	localparam logic [9:0] MRESR_IDX_BLOCK      = 10'h02c;
	localparam logic [9:0] MRESR_IDX_AUX_ONE    = 10'h02d;
	localparam logic [9:0] MRESR_IDX_IRQ_STATUS = 10'h030;
	localparam logic [9:0] MRESR_IDX_IRQ_ENABLE = 10'h031;
	localparam logic [9:0] MRESR_IDX_IRQ_CLEAR  = 10'h032;

	// ------------------------------------------------------------
	// Field layout and reset values
	// ------------------------------------------------------------
	localparam int          MRESR_NUM_CELLS     = 12;
	localparam int          MRESR_NUM_RESULTS   = 14;
	localparam int          MRESR_CELL_BITS     = 14;
	localparam int          MRESR_AUX_BITS      = 12;
	localparam int          MRESR_CELL_LSB      = 2;
	localparam int          MRESR_AUX_LSB       = 4;
	localparam int          MRESR_TOP_BITS      = 4;
	localparam logic [3:0]  MRESR_TOP_CELL_RST  = 4'hc;
	localparam logic [15:0] MRESR_RESULT_RST    = 16'h0000;
	localparam logic [3:0]  MRESR_SLOT_BLOCK    = 4'hc;
	localparam logic [3:0]  MRESR_SLOT_AUX_ONE  = 4'hd;

	// Interrupt status bit positions
	localparam int          MRESR_EV_CELL       = 0;
	localparam int          MRESR_EV_BLOCK      = 1;
	localparam int          MRESR_EV_AUX        = 2;
	localparam int          MRESR_EV_ALERT      = 3;
	localparam int          MRESR_NUM_EV        = 4;
	localparam logic [3:0]  MRESR_IRQ_EN_RST    = 4'h0;

endpackage : mresr_pkg

// file: logic/mresr_conv_if.sv
// Conversion result write path between the top and the result store
`timescale 1ns/10ps
interface mresr_conv_if;
	logic        valid;
	logic [3:0]  slot;
	logic [13:0] data;

	modport src (output valid, output slot, output data);
	modport dst (input valid, input slot, input data);
endinterface : mresr_conv_if

// file: logic/mresr_result_store.sv
// Flip-flop storage of the formatted conversion results
`timescale 1ns/10ps
module mresr_result_store import mresr_pkg::*; #(
	parameter int NUM_SLOTS = MRESR_NUM_RESULTS
) (
	input  wire logic                 pclk,
	input  wire logic                 presetn,
	mresr_conv_if.dst                 conv,
	input  wire logic [3:0]           rd_slot,
	output      logic [15:0]          rd_value
);

	// ------------------------------------------------------------
	// Storage
	// ------------------------------------------------------------
	if (NUM_SLOTS != MRESR_NUM_RESULTS) begin : g_chk
		$error("mresr_result_store: slot count must match the register map");
	end

	logic [15:0] mem_q [NUM_SLOTS];
	logic [15:0] fmt_d;

	// Aux keeps twelve bits, cells and block keep fourteen
	assign fmt_d = (conv.slot == MRESR_SLOT_AUX_ONE) ?
		{conv.data[MRESR_AUX_BITS-1:0], 4'h0} :
		{conv.data, 2'h0};

	// Only the conversion path writes here, never the bus
	for (genvar i = 0; i < NUM_SLOTS; i++) begin : g_slot
		always_ff @(posedge pclk or negedge presetn) begin
			if (!presetn) begin
				mem_q[i] <= MRESR_RESULT_RST;
			end else if (conv.valid && conv.slot == 4'(i)) begin
				mem_q[i] <= fmt_d;
			end
		end
	end

	assign rd_value = (32'(rd_slot) < NUM_SLOTS) ? mem_q[rd_slot] : 16'h0000;

endmodule : mresr_result_store

// file: logic/mresr_alert_mask.sv
// Masks balance-switch diagnostic alerts above the highest used channel
`timescale 1ns/10ps
module mresr_alert_mask import mresr_pkg::*; #(
	parameter int NUM_CELLS = MRESR_NUM_CELLS
) (
	input  wire logic [3:0]           top_cfg,
	input  wire logic [NUM_CELLS-1:0] raw_alert,
	output      logic [3:0]           top_eff,
	output      logic [NUM_CELLS-1:0] masked_alert
);

	// ------------------------------------------------------------
	// Effective top cell
	// ------------------------------------------------------------
	if (NUM_CELLS < 1 || NUM_CELLS > 15) begin : g_chk
		$error("mresr_alert_mask: cell count must be 1 to 15");
	end

	// Zero, or beyond the last channel, falls back to all channels
	assign top_eff = (top_cfg == 4'h0 || 32'(top_cfg) > NUM_CELLS) ?
		MRESR_TOP_CELL_RST : top_cfg;

	for (genvar i = 0; i < NUM_CELLS; i++) begin : g_mask
		assign masked_alert[i] = raw_alert[i] && (32'(top_eff) > i);
	end

endmodule : mresr_alert_mask

// file: verif/mresr_top_asserts.sv
// Assertion checker for the measurement result register bank
`timescale 1ns/10ps
module mresr_top_asserts import mresr_pkg::*; #(
	parameter int NUM_CELLS = MRESR_NUM_CELLS
) (
	input wire logic                 pclk,
	input wire logic                 presetn,
	input wire logic                 psel,
	input wire logic                 penable,
	input wire logic                 pwrite,
	input wire logic [11:0]          paddr,
	input wire logic [31:0]          pwdata,
	input wire logic [3:0]           pstrb,
	input wire logic [31:0]          prdata,
	input wire logic                 pready,
	input wire logic                 pslverr,
	input wire logic                 conv_valid,
	input wire logic [3:0]           conv_slot,
	input wire logic [13:0]          conv_data,
	input wire logic [NUM_CELLS-1:0] balance_switch_diag_alert_raw,
	input wire logic [NUM_CELLS-1:0] balance_switch_diag_alert,
	input wire logic [3:0]           highest_used_channel,
	input wire logic                 irq
);
	// --------------------------------------------------------
	// Helper logic
	// --------------------------------------------------------
	logic [3:0] top_exp_q;
	wire        rd_acc = psel && penable && !pwrite;
	wire        top_wr = psel && penable && pwrite && pstrb[0] && paddr == 12'h078;
	wire        res_rd = rd_acc && paddr >= 12'h080 && paddr <= 12'h0b0;
	// Zero and out-of-range writes fall back to twelve
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) top_exp_q <= 4'hc;
		else if (top_wr) top_exp_q <= (pwdata[3:0] == 4'h0 || pwdata[3:0] > 4'hc) ? 4'hc : pwdata[3:0];
	end
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	// --------------------------------------------------------
	// Properties
	// --------------------------------------------------------
	AST_TOP_RANGE: assert property (highest_used_channel inside {[4'h1:4'hc]})
		else $error("effective top cell out of range");
	AST_TOP_FOLLOW: assert property (top_wr |-> ##[1:2] highest_used_channel == top_exp_q)
		else $error("effective top cell does not follow write");
	AST_TOP_HOLD: assert property (!top_wr [*3] |-> highest_used_channel == top_exp_q)
		else $error("effective top cell changed without write");
	AST_ALERT_MASK: assert property ($stable(highest_used_channel) |-> (balance_switch_diag_alert >> highest_used_channel) == '0)
		else $error("alert above top cell passed");
	AST_ALERT_CAUSE: assert property ((balance_switch_diag_alert & ~$past(balance_switch_diag_alert_raw)) == '0)
		else $error("alert without raw cause");
	AST_PREADY: assert property (psel && penable |-> pready)
		else $error("access not completed");
	AST_RESULT_LOW: assert property (res_rd |-> prdata[1:0] == 2'h0 && prdata[31:16] == 16'h0000)
		else $error("result low bits not zero");
	AST_AUX_LOW: assert property (rd_acc && paddr == 12'h0b4 |-> prdata[3:0] == 4'h0)
		else $error("aux low bits not zero");
	AST_TOP_HIGH: assert property (rd_acc && paddr == 12'h078 |-> prdata[31:4] == 28'h0000000)
		else $error("top cell reserved bits not zero");
endmodule : mresr_top_asserts

bind mresr_top mresr_top_asserts #(.NUM_CELLS(NUM_CELLS)) chk_u (.pclk(pclk), .presetn(presetn),
	.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
	.prdata(prdata), .pready(pready), .pslverr(pslverr), .conv_valid(conv_valid),
	.conv_slot(conv_slot), .conv_data(conv_data), .irq(irq),
	.balance_switch_diag_alert_raw(balance_switch_diag_alert_raw),
	.balance_switch_diag_alert(balance_switch_diag_alert), .highest_used_channel(highest_used_channel));

// file: verif/mresr_top_tb.sv
// Self-checking testbench for the measurement result register bank
`timescale 1ns/10ps
module mresr_top_tb;
	typedef struct {logic [3:0] slot; logic [13:0] data; logic [11:0] addr; logic [31:0] exp;} mresr_row_t;
	logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic        conv_valid = 1'b0, pready, pslverr, irq, last_err;
	logic [11:0] paddr = 12'h000, raw = 12'h000, alert;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic [3:0]  pstrb = 4'hf, conv_slot = 4'h0, top;
	logic [13:0] conv_data = 14'h0;
	int          err_total = 0, compares = 0;
	mresr_row_t  rows [5] = '{'{4'h0, 14'h3fff, 12'h080, 32'hfffc}, '{4'h5, 14'h2aaa, 12'h094, 32'haaa8},
		'{4'hb, 14'h1235, 12'h0ac, 32'h48d4}, '{4'hc, 14'h0001, 12'h0b0, 32'h0004},
		'{4'hd, 14'h3abc, 12'h0b4, 32'habc0}};
	always #10 pclk = ~pclk;
	mresr_top dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .conv_valid(conv_valid), .conv_slot(conv_slot), .conv_data(conv_data),
		.balance_switch_diag_alert_raw(raw), .balance_switch_diag_alert(alert),
		.highest_used_channel(top), .irq(irq));
	// --------------------------------------------------------
	// Shared tasks
	// --------------------------------------------------------
	task automatic test_done();
		$display("compares %0d err_total %0d", compares, err_total);
		if (err_total == 0 && compares > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask : test_done
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			err_total++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : chk
	// Called right after a rising edge; zero-wait slave still gets a bounded wait
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
		int n;
		n = 0;
		psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1 && n < 20) begin
			n++;
			@(posedge pclk);
		end
		if (n == 20) begin
			err_total++;
			test_done();
		end
		rd = prdata;
		last_err = pslverr;
		psel <= 1'b0; penable <= 1'b0;
		@(posedge pclk);
	endtask : apb
	task automatic conv(input logic [3:0] s, input logic [13:0] d);
		conv_valid <= 1'b1; conv_slot <= s; conv_data <= d;
		@(posedge pclk);
		conv_valid <= 1'b0;
		@(posedge pclk);
	endtask : conv
	// --------------------------------------------------------
	// Main sequence
	// --------------------------------------------------------
	initial begin
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		chk(top, 4'hc);
		apb(1'b0, 12'h078, 32'h0); chk(rd, 32'hc);
		apb(1'b0, 12'h0ac, 32'h0); chk(rd, 32'h0);
		foreach (rows[i]) begin
			conv(rows[i].slot, rows[i].data);
			apb(1'b0, rows[i].addr, 32'h0); chk(rd, rows[i].exp);
			apb(1'b1, rows[i].addr, 32'hffffffff);
			apb(1'b0, rows[i].addr, 32'h0); chk(rd, rows[i].exp);
		end
		raw <= 12'hfff;
		apb(1'b1, 12'h078, 32'h5);
		repeat (3) @(posedge pclk);
		chk(top, 4'h5); chk(alert, 12'h01f);
		apb(1'b1, 12'h078, 32'h1);
		repeat (3) @(posedge pclk);
		chk(alert, 12'h001);
		apb(1'b1, 12'h078, 32'h0);
		repeat (3) @(posedge pclk);
		chk(top, 4'hc); chk(alert, 12'hfff);
		apb(1'b1, 12'h078, 32'hfff3);
		apb(1'b0, 12'h078, 32'h0); chk(rd, 32'h3);
		// Interrupt: clear all four stale events, enable cell event only
		apb(1'b1, 12'h0c8, 32'hf); apb(1'b1, 12'h0c4, 32'h1);
		chk(irq, 1'b0);
		conv(4'h2, 14'h0100);
		@(posedge pclk);
		chk(irq, 1'b1);
		apb(1'b0, 12'h0c0, 32'h0); chk(rd & 32'h1, 32'h1);
		apb(1'b1, 12'h0c8, 32'h1);
		@(posedge pclk);
		chk(irq, 1'b0);
		apb(1'b1, 12'h0c4, 32'h0);
		conv(4'hc, 14'h0002);
		@(posedge pclk);
		chk(irq, 1'b0);
		apb(1'b0, 12'h07a, 32'h0);
		chk(32'(last_err), 32'h1);
		chk(rd, 32'h0);
		test_done();
	end
endmodule : mresr_top_tb
